// ---- bench/sftx_remote.sv ----
// bench model of the remote link layer: credits and frame acknowledgements
`timescale 1ns/100ps
module sftx_remote
   import sftx_pkg::*;
#(
   parameter int ACK_DLY = 3
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // bench control
   input  wire logic give_rrdy,
   input  wire logic auto_ack,
   input  wire logic nak_sel,
   // link events
   input  wire logic eof_sent,
   output logic      ack_rcvd,
   output logic      nak_rcvd,
   output logic      rrdy_rcvd
);
   logic [ACK_DLY-1:0] pend_r;
   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pend_r    <= '0;
         ack_rcvd  <= 1'b0;
         nak_rcvd  <= 1'b0;
         rrdy_rcvd <= 1'b0;
      end else begin
         pend_r    <= {pend_r[ACK_DLY-2:0], eof_sent & auto_ack};
         ack_rcvd  <= pend_r[ACK_DLY-1] & ~nak_sel;
         nak_rcvd  <= pend_r[ACK_DLY-1] & nak_sel;
         rrdy_rcvd <= give_rrdy;
      end
   end
endmodule : sftx_remote

// ---- bench/testbench.sv ----
// self-checking bench for the frame transmit control
`timescale 1ns/100ps
module testbench
   import sftx_pkg::*;
();
   localparam int TMO = 20;
   logic        CORE_CLK, RSTN, CONN_ENTER, TX_FRAME_REQ, TX_INTERLOCKED;
   logic        CLOSE_REQ, FD_VALID, FD_READY, FD_LAST, ACK_RCVD, NAK_RCVD;
   logic        RRDY_RCVD, ALIGN_REQ, RRDY_TX_REQ, ACKNAK_TX_REQ, ACK_TMO;
   logic        CREDIT_TMO, DONE_SENT_CNF, ACK_RCVD_CNF, NAK_RCVD_CNF, IDLE;
   logic        DONE_WAIT_REQ, BALANCED, CREDIT_AVAIL, DW_VALID;
   logic        FRAME_DW_SENT, EOF_SENT, IDLE_SENT;
   logic        give_rrdy, auto_ack, nak_sel;
   logic [1:0]  DONE_REASON;
   logic [2:0]  DW_KIND;
   logic [31:0] FD_DATA, DW_DATA;
   int          mismatches, checks;
   ////////////////////////////////////////////////////////////////////////
   sftx_top #(.TMO_CYC(TMO)) uut (.CORE_CLK(CORE_CLK), .RSTN(RSTN),
      .CONN_ENTER(CONN_ENTER), .TX_FRAME_REQ(TX_FRAME_REQ),
      .TX_INTERLOCKED(TX_INTERLOCKED), .CLOSE_REQ(CLOSE_REQ),
      .FD_VALID(FD_VALID), .FD_READY(FD_READY), .FD_DATA(FD_DATA),
      .FD_LAST(FD_LAST), .ACK_RCVD(ACK_RCVD), .NAK_RCVD(NAK_RCVD),
      .RRDY_RCVD(RRDY_RCVD), .ALIGN_REQ(ALIGN_REQ),
      .RRDY_TX_REQ(RRDY_TX_REQ), .ACKNAK_TX_REQ(ACKNAK_TX_REQ),
      .ACK_TMO(ACK_TMO), .CREDIT_TMO(CREDIT_TMO),
      .DONE_SENT_CNF(DONE_SENT_CNF), .ACK_RCVD_CNF(ACK_RCVD_CNF),
      .NAK_RCVD_CNF(NAK_RCVD_CNF), .IDLE(IDLE),
      .DONE_WAIT_REQ(DONE_WAIT_REQ), .DONE_REASON(DONE_REASON),
      .BALANCED(BALANCED), .CREDIT_AVAIL(CREDIT_AVAIL),
      .DW_KIND(DW_KIND), .DW_DATA(DW_DATA), .DW_VALID(DW_VALID),
      .FRAME_DW_SENT(FRAME_DW_SENT), .EOF_SENT(EOF_SENT),
      .IDLE_SENT(IDLE_SENT));
   sftx_remote remote (.clk(CORE_CLK), .rstn(RSTN), .give_rrdy(give_rrdy),
      .auto_ack(auto_ack), .nak_sel(nak_sel), .eof_sent(EOF_SENT),
      .ack_rcvd(ACK_RCVD), .nak_rcvd(NAK_RCVD), .rrdy_rcvd(RRDY_RCVD));
   always #50 CORE_CLK = ~CORE_CLK;
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic tick;
      @(posedge CORE_CLK);
      #1;
   endtask : tick
   task automatic chk(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t exp=0x%0h got=0x%0h", $time, exp, got);
      end
   endtask : chk
   task automatic wait_on(input int sel, input int lim, output int n);
      logic s;
      n = 0;
      s = 1'b0;
      while (s !== 1'b1) begin
         tick();
         n++;
         case (sel)
            0: s = DONE_SENT_CNF;
            1: s = ACK_TMO;
            2: s = CREDIT_TMO;
            3: s = ACK_RCVD_CNF;
            default: s = NAK_RCVD_CNF;
         endcase
         if (n > lim) begin
            mismatches++;
            $display("BAD t=%0t wait 0x%0h n=0x%0h", $time, sel, n);
            tally_and_finish();
         end
      end
   endtask : wait_on
   task automatic give_up(input int what);
      mismatches++;
      $display("BAD t=%0t limit 0x%0h exp=0x1 got=0x0", $time, what);
      tally_and_finish();
   endtask : give_up
   task automatic request(input logic f, input logic il, input logic c);
      int n;
      TX_FRAME_REQ = f;
      TX_INTERLOCKED = il;
      CLOSE_REQ = c;
      n = 0;
      do begin
         tick();
         n++;
      end while (IDLE !== 1'b0 && n < 10);
      if (IDLE !== 1'b0) give_up(1);
      chk(0, IDLE);
      TX_FRAME_REQ = 0;
      TX_INTERLOCKED = 0;
      CLOSE_REQ = 0;
   endtask : request
   task automatic expect_done(input logic [1:0] why);
      int n;
      wait_on(0, 40, n);
      chk(1, DONE_WAIT_REQ);
      chk(why, DONE_REASON);
      tick();
      chk(1, IDLE);
   endtask : expect_done
   task automatic conn(input logic rr);
      CONN_ENTER = 1;
      give_rrdy = rr;
      tick();
      CONN_ENTER = 0;
      give_rrdy = 0;
      tick();
      tick();
   endtask : conn
   task automatic feed;
      int n;
      for (int k = 0; k < 3; k++) begin
         FD_VALID = 1;
         FD_DATA = 32'h100 + k;
         FD_LAST = (k == 2);
         n = 0;
         do begin
            @(posedge CORE_CLK);
            n++;
         end while (FD_READY !== 1'b1 && n < 200);
         if (FD_READY !== 1'b1) give_up(2);
         #1;
      end
      FD_VALID = 0;
      FD_LAST = 0;
   endtask : feed
   task automatic watch(output int nd);
      logic sof;
      int   n;
      sof = 0;
      nd = 0;
      for (n = 0; n < 200 && EOF_SENT !== 1'b1; n++) begin
         tick();
         if (DW_KIND === DW_SOF) sof = 1;
         if (FRAME_DW_SENT === 1'b1) begin
            chk(1, sof);
            chk(32'h100 + nd, DW_DATA);
            nd++;
         end
      end
      if (EOF_SENT !== 1'b1) give_up(3);
      chk(DW_EOF, DW_KIND);
   endtask : watch
   task automatic send_frame(input logic il);
      int nd;
      fork
         feed();
         request(1, il, 0);
         watch(nd);
      join
      chk(3, nd);
      tick();
      chk(1, IDLE);
   endtask : send_frame
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(1, IDLE);
      chk(1, BALANCED);
      chk(0, CREDIT_AVAIL);
      chk(DW_IDLE, DW_KIND);
      chk(1, DW_VALID);
      $display("test reset done");
   endtask : t_reset
   task automatic t_credit_tmo;
      int n;
      conn(0);
      request(1, 0, 0);
      wait_on(2, TMO + 10, n);
      chk(1, n >= TMO - 1 && n <= TMO + 4);
      expect_done(REASON_CREDIT_TMO);
      $display("test credit timeout done");
   endtask : t_credit_tmo
   task automatic t_frame;
      conn(1);
      chk(1, CREDIT_AVAIL);
      send_frame(0);
      chk(0, CREDIT_AVAIL);
      chk(0, BALANCED);
      $display("test frame done");
   endtask : t_frame
   task automatic t_ack_tmo;
      int n;
      request(1, 1, 0);
      wait_on(1, TMO + 10, n);
      chk(1, n >= TMO - 2 && n <= TMO + 4);
      expect_done(REASON_ACK_TMO);
      give_rrdy = 1;
      tick();
      give_rrdy = 0;
      conn(0);
      chk(1, BALANCED);
      chk(0, CREDIT_AVAIL);
      $display("test ack timeout done");
   endtask : t_ack_tmo
   task automatic t_acknak;
      int n;
      auto_ack = 1;
      for (int k = 0; k < 2; k++) begin
         nak_sel = k[0];
         conn(1);
         send_frame(1);
         wait_on(3 + k, 20, n);
         tick();
         chk(1, BALANCED);
      end
      $display("test ack nak done");
   endtask : t_acknak
   task automatic t_close;
      request(0, 0, 1);
      expect_done(REASON_CLOSE);
      $display("test close done");
   endtask : t_close
   task automatic t_prio;
      logic [2:0] rq [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
      logic [2:0] ex [4] = '{DW_ALIGN, DW_RRDY, DW_ACKNAK, DW_IDLE};
      for (int k = 0; k < 4; k++) begin
         {ALIGN_REQ, RRDY_TX_REQ, ACKNAK_TX_REQ} = rq[k];
         tick();
         tick();
         chk(ex[k], DW_KIND);
      end
      chk(1, IDLE_SENT);
      $display("test priority done");
   endtask : t_prio
   ////////////////////////////////////////////////////////////////////////
   initial begin
      CORE_CLK = 0;
      RSTN = 0;
      {CONN_ENTER, TX_FRAME_REQ, TX_INTERLOCKED, CLOSE_REQ} = '0;
      {FD_VALID, FD_LAST, ALIGN_REQ, RRDY_TX_REQ, ACKNAK_TX_REQ} = '0;
      {give_rrdy, auto_ack, nak_sel} = '0;
      FD_DATA = '0;
      mismatches = 0;
      checks = 0;
      repeat (16) tick();
      RSTN = 1;
      tick();
      t_reset();
      t_credit_tmo();
      t_frame();
      t_ack_tmo();
      t_acknak();
      t_close();
      t_prio();
      tally_and_finish();
   end
endmodule : testbench

// ---- rtl/sftx_buf2.sv ----
// two-entry valid/ready buffer for frame dwords
`timescale 1ns/100ps
module sftx_buf2
   import sftx_pkg::*;
#(
   parameter int W = 32
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   typedef struct packed {
      logic [1:0][W-1:0] mem;
      logic              rd;
      logic              wr;
      logic [1:0]        cnt;
   } sftx_buf_t;
   sftx_buf_t s_r, s_nxt;
   logic push, pop;

   assign in_ready  = (s_r.cnt != 2'h2);
   assign out_valid = (s_r.cnt != 2'h0);
   assign out_data  = s_r.mem[s_r.rd];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_comb begin
      s_nxt = s_r;
      if (push) begin
         s_nxt.mem[s_r.wr] = in_data;
         s_nxt.wr = ~s_r.wr;
      end
      if (pop) begin
         s_nxt.rd = ~s_r.rd;
      end
      s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   chk_stall_holds: assert property (
      @(posedge clk) disable iff (!rstn)
      out_valid && !out_ready
      |=> out_valid && $stable(out_data))
      else $error("stalled word lost");
endmodule : sftx_buf2

// ---- rtl/sftx_pkg.sv ----
// package: states, reasons and timing constants for the frame transmit control
package sftx_pkg;
   // frame transmit control states
   typedef enum logic [2:0] {
      FRAME_TX_IDLE_STATE,
      ACK_BALANCE_WAIT_STATE,
      TX_CREDIT_WAIT_STATE,
      FRAME_REQUEST_STATE,
      DONE_REQUEST_STATE
   } sftx_state_t;
   // dword scheduler states
   typedef enum logic [2:0] {
      SCH_IDLE,
      SCH_SOF,
      SCH_BODY,
      SCH_EOF
   } sftx_sch_t;
   // done reason codes
   localparam logic [1:0] REASON_CLOSE      = 2'h0;
   localparam logic [1:0] REASON_ACK_TMO    = 2'h1;
   localparam logic [1:0] REASON_CREDIT_TMO = 2'h2;
   // scheduler dword kinds
   localparam logic [2:0] DW_IDLE   = 3'h0;
   localparam logic [2:0] DW_ALIGN  = 3'h1;
   localparam logic [2:0] DW_RRDY   = 3'h2;
   localparam logic [2:0] DW_ACKNAK = 3'h3;
   localparam logic [2:0] DW_DONE   = 3'h4;
   localparam logic [2:0] DW_SOF    = 3'h5;
   localparam logic [2:0] DW_FRAME  = 3'h6;
   localparam logic [2:0] DW_EOF    = 3'h7;
   // timing
   localparam int CLK_HZ        = 10_000_000;
   localparam int TIMEOUT_US    = 1000;
   localparam int TIMEOUT_CYC   = CLK_HZ / 1_000_000 * TIMEOUT_US;
   localparam int CNT_W         = 8;
   localparam int CREDIT_INIT   = 0;
endpackage : sftx_pkg

// ---- rtl/sftx_sched.sv ----
// dword scheduler: primitive priority and sof/frame/eof framing
`timescale 1ns/100ps
module sftx_sched
   import sftx_pkg::*;
#(
   parameter int W = 32
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rstn,
   // primitive requests
   input  wire logic         align_req,
   input  wire logic         rrdy_req,
   input  wire logic         acknak_req,
   input  wire logic         done_req,
   input  wire logic         frame_req,
   // frame dword stream
   input  wire logic         fd_valid,
   output logic              fd_ready,
   input  wire logic         fd_last,
   // outputs
   output logic [2:0]        dw_kind,
   output logic              dw_valid,
   output logic              frame_dw_sent,
   output logic              eof_sent,
   output logic              idle_sent,
   output logic              done_sent
);
   typedef struct packed {
      sftx_sch_t  st;
      logic [2:0] kind;
      logic       fsent;
      logic       esent;
      logic       isent;
      logic       dsent;
      logic       fpend;
      logic       dpend;
   } sftx_sch_st_t;
   sftx_sch_st_t s_r, s_nxt;
   logic         fp, dp;

   // requests stay pending until a free slot takes them
   assign fp = s_r.fpend || frame_req;
   assign dp = s_r.dpend || done_req;

   always_comb begin
      s_nxt = s_r;
      s_nxt.fsent = 1'b0;
      s_nxt.esent = 1'b0;
      s_nxt.isent = 1'b0;
      s_nxt.dsent = 1'b0;
      s_nxt.fpend = fp;
      s_nxt.dpend = dp;
      fd_ready = 1'b0;
      if (align_req) begin
         s_nxt.kind = DW_ALIGN;
      end else if (rrdy_req) begin
         s_nxt.kind = DW_RRDY;
      end else if (acknak_req) begin
         s_nxt.kind = DW_ACKNAK;
      end else if (dp && s_r.st == SCH_IDLE) begin
         s_nxt.kind = DW_DONE;
         s_nxt.dsent = 1'b1;
         s_nxt.dpend = 1'b0;
      end else begin
         unique case (s_r.st)
            SCH_IDLE: begin
               if (fp) begin
                  s_nxt.kind = DW_SOF;
                  s_nxt.fpend = 1'b0;
                  s_nxt.st = SCH_BODY;
               end else begin
                  s_nxt.kind = DW_IDLE;
                  s_nxt.isent = 1'b1;
               end
            end
            SCH_BODY: begin
               fd_ready = 1'b1;
               if (fd_valid) begin
                  s_nxt.kind = DW_FRAME;
                  s_nxt.fsent = 1'b1;
                  if (fd_last) begin
                     s_nxt.st = SCH_EOF;
                  end
               end else begin
                  s_nxt.kind = DW_IDLE;
                  s_nxt.isent = 1'b1;
               end
            end
            SCH_EOF: begin
               s_nxt.kind = DW_EOF;
               s_nxt.esent = 1'b1;
               s_nxt.st = SCH_IDLE;
            end
            default: begin
               s_nxt.st = SCH_IDLE;
               s_nxt.kind = DW_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_r <= '{st: SCH_IDLE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dw_kind       = s_r.kind;
   assign dw_valid      = rstn;
   assign frame_dw_sent = s_r.fsent;
   assign eof_sent      = s_r.esent;
   assign idle_sent     = s_r.isent;
   assign done_sent     = s_r.dsent;

   chk_eof_after_body: assert property (
      @(posedge clk) disable iff (!rstn)
      s_r.st == SCH_EOF && !align_req && !rrdy_req && !acknak_req
      |=> eof_sent && dw_kind == DW_EOF)
      else $error("eof not sent after last frame dword");
endmodule : sftx_sched

// ---- rtl/sftx_top.sv ----
// frame transmit control with interlock and credit monitors
`timescale 1ns/100ps
module sftx_top
   import sftx_pkg::*;
#(
   parameter int TMO_CYC = TIMEOUT_CYC,
   parameter int CW      = CNT_W,
   parameter int DW      = 32
) (
   // clock and reset
   input  wire logic          CORE_CLK,
   input  wire logic          RSTN,
   // connection control
   input  wire logic          CONN_ENTER,
   // port layer requests
   input  wire logic          TX_FRAME_REQ,
   input  wire logic          TX_INTERLOCKED,
   input  wire logic          CLOSE_REQ,
   // frame dword source
   input  wire logic          FD_VALID,
   output logic               FD_READY,
   input  wire logic [DW-1:0] FD_DATA,
   input  wire logic          FD_LAST,
   // remote events
   input  wire logic          ACK_RCVD,
   input  wire logic          NAK_RCVD,
   input  wire logic          RRDY_RCVD,
   // primitive requests from other link machines
   input  wire logic          ALIGN_REQ,
   input  wire logic          RRDY_TX_REQ,
   input  wire logic          ACKNAK_TX_REQ,
   // port layer confirmations
   output logic               ACK_TMO,
   output logic               CREDIT_TMO,
   output logic               DONE_SENT_CNF,
   output logic               ACK_RCVD_CNF,
   output logic               NAK_RCVD_CNF,
   output logic               IDLE,
   // done wait notice
   output logic               DONE_WAIT_REQ,
   output logic [1:0]         DONE_REASON,
   // monitor flags
   output logic               BALANCED,
   output logic               CREDIT_AVAIL,
   // scheduler output
   output logic [2:0]         DW_KIND,
   output logic [DW-1:0]      DW_DATA,
   output logic               DW_VALID,
   output logic               FRAME_DW_SENT,
   output logic               EOF_SENT,
   output logic               IDLE_SENT
);
   localparam int TW = $clog2(TMO_CYC + 1);

   typedef struct packed {
      sftx_state_t   st;
      logic          ilk;
      logic          cls;
      logic [1:0]    reason;
      logic [TW-1:0] tmr;
      logic [CW-1:0] eof_cnt;
      logic [CW-1:0] an_cnt;
      logic [CW-1:0] credit;
      logic          fr_issued;
      logic          done_issued;
      logic          ack_tmo;
      logic          cr_tmo;
      logic          done_cnf;
      logic          dwait;
      logic          ack_cnf;
      logic          nak_cnf;
      logic [DW-1:0] dw_data;
   } sftx_top_t;
   sftx_top_t s_r, s_nxt;

   logic          frame_req, done_req, eof_sent, done_sent;
   logic          sch_ready, buf_valid, buf_last;
   logic          credit_used, balanced, credit_avail, tmr_exp;
   logic [DW:0]   buf_data;

   ////////////////////////////////////////////////////////////////////
   // frame dword buffer and scheduler
   sftx_buf2 #(.W(DW + 1)) u_buf (
      .clk       (CORE_CLK),
      .rstn      (RSTN),
      .in_valid  (FD_VALID),
      .in_ready  (FD_READY),
      .in_data   ({FD_LAST, FD_DATA}),
      .out_valid (buf_valid),
      .out_ready (sch_ready),
      .out_data  (buf_data)
   );
   assign buf_last = buf_data[DW];

   sftx_sched #(.W(DW)) u_sched (
      .clk           (CORE_CLK),
      .rstn          (RSTN),
      .align_req     (ALIGN_REQ),
      .rrdy_req      (RRDY_TX_REQ),
      .acknak_req    (ACKNAK_TX_REQ),
      .done_req      (done_req),
      .frame_req     (frame_req),
      .fd_valid      (buf_valid),
      .fd_ready      (sch_ready),
      .fd_last       (buf_last),
      .dw_kind       (DW_KIND),
      .dw_valid      (DW_VALID),
      .frame_dw_sent (FRAME_DW_SENT),
      .eof_sent      (eof_sent),
      .idle_sent     (IDLE_SENT),
      .done_sent     (done_sent)
   );

   ////////////////////////////////////////////////////////////////////
   // monitors and control
   assign balanced     = (s_r.an_cnt == s_r.eof_cnt);
   assign credit_avail = (s_r.credit != '0);
   assign tmr_exp      = (s_r.tmr == '0);
   assign credit_used  = (s_r.st == TX_CREDIT_WAIT_STATE) && credit_avail;
   assign frame_req    = (s_r.st == FRAME_REQUEST_STATE) && !s_r.fr_issued;
   assign done_req     = (s_r.st == DONE_REQUEST_STATE) && !s_r.done_issued;

   always_comb begin
      s_nxt = s_r;
      s_nxt.ack_tmo  = 1'b0;
      s_nxt.cr_tmo   = 1'b0;
      s_nxt.done_cnf = 1'b0;
      s_nxt.dwait    = 1'b0;
      s_nxt.ack_cnf  = ACK_RCVD;
      s_nxt.nak_cnf  = NAK_RCVD;
      if (sch_ready && buf_valid) begin
         s_nxt.dw_data = buf_data[DW-1:0];
      end
      if (ACK_RCVD || NAK_RCVD) begin
         s_nxt.an_cnt = s_r.an_cnt + 1'b1;
      end
      // credit: add on rrdy, subtract on use, floor at zero
      s_nxt.credit = s_r.credit + {{(CW-1){1'b0}}, RRDY_RCVD}
         - {{(CW-1){1'b0}}, credit_used};
      if (!tmr_exp) begin
         s_nxt.tmr = s_r.tmr - 1'b1;
      end
      unique case (s_r.st)
         FRAME_TX_IDLE_STATE: begin
            if (TX_FRAME_REQ || CLOSE_REQ) begin
               s_nxt.st  = ACK_BALANCE_WAIT_STATE;
               s_nxt.ilk = TX_INTERLOCKED;
               s_nxt.cls = CLOSE_REQ;
               s_nxt.tmr = TW'(TMO_CYC);
            end
         end
         ACK_BALANCE_WAIT_STATE: begin
            if (s_r.cls && balanced) begin
               s_nxt.st     = DONE_REQUEST_STATE;
               s_nxt.reason = REASON_CLOSE;
            end else if (!s_r.cls && (!s_r.ilk || balanced)) begin
               s_nxt.st  = TX_CREDIT_WAIT_STATE;
               s_nxt.tmr = TW'(TMO_CYC);
            end else if (tmr_exp) begin
               s_nxt.ack_tmo = 1'b1;
               s_nxt.st      = DONE_REQUEST_STATE;
               s_nxt.reason  = REASON_ACK_TMO;
            end
         end
         TX_CREDIT_WAIT_STATE: begin
            if (credit_avail) begin
               s_nxt.st        = FRAME_REQUEST_STATE;
               s_nxt.fr_issued = 1'b0;
            end else if (tmr_exp) begin
               s_nxt.cr_tmo = 1'b1;
               s_nxt.st     = DONE_REQUEST_STATE;
               s_nxt.reason = REASON_CREDIT_TMO;
            end
         end
         FRAME_REQUEST_STATE: begin
            s_nxt.fr_issued = 1'b1;
            if (eof_sent) begin
               s_nxt.eof_cnt = s_r.eof_cnt + 1'b1;
               s_nxt.st      = FRAME_TX_IDLE_STATE;
            end
         end
         DONE_REQUEST_STATE: begin
            s_nxt.done_issued = 1'b1;
            if (done_sent) begin
               s_nxt.dwait    = 1'b1;
               s_nxt.done_cnf = 1'b1;
               s_nxt.st       = FRAME_TX_IDLE_STATE;
            end
         end
      endcase
      if (s_nxt.st != DONE_REQUEST_STATE) begin
         s_nxt.done_issued = 1'b0;
      end
      if (CONN_ENTER) begin
         s_nxt.st      = FRAME_TX_IDLE_STATE;
         s_nxt.an_cnt  = s_nxt.eof_cnt;
         s_nxt.credit  = CW'(CREDIT_INIT);
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         s_r <= '{st: FRAME_TX_IDLE_STATE, default: '0};
      end else begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   assign ACK_TMO       = s_r.ack_tmo;
   assign CREDIT_TMO    = s_r.cr_tmo;
   assign DONE_SENT_CNF = s_r.done_cnf;
   assign DONE_WAIT_REQ = s_r.dwait;
   assign DONE_REASON   = s_r.reason;
   assign ACK_RCVD_CNF  = s_r.ack_cnf;
   assign NAK_RCVD_CNF  = s_r.nak_cnf;
   assign IDLE          = (s_r.st == FRAME_TX_IDLE_STATE);
   assign BALANCED      = balanced;
   assign CREDIT_AVAIL  = credit_avail;
   assign DW_DATA       = s_r.dw_data;
   assign EOF_SENT      = eof_sent;

   ////////////////////////////////////////////////////////////////////
   // checks
   chk_idle_leave_req: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      IDLE && !CONN_ENTER && (TX_FRAME_REQ || CLOSE_REQ)
      |=> s_r.st == ACK_BALANCE_WAIT_STATE)
      else $error("idle did not leave on request");
   chk_ilk_carried: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      IDLE && !CONN_ENTER && TX_FRAME_REQ
      |=> s_r.ilk == $past(TX_INTERLOCKED))
      else $error("interlock flag lost");
   chk_close_carried: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      IDLE && !CONN_ENTER && CLOSE_REQ
      |=> s_r.cls)
      else $error("close flag lost");
   chk_timer_load: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      s_r.st == ACK_BALANCE_WAIT_STATE && $past(IDLE)
      |-> s_r.tmr == TW'(TMO_CYC))
      else $error("ack timer not loaded");
   chk_nonilk_pass: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      s_r.st == ACK_BALANCE_WAIT_STATE && !s_r.ilk && !s_r.cls && !CONN_ENTER
      |=> s_r.st == TX_CREDIT_WAIT_STATE)
      else $error("non-interlocked frame dwelt");
   chk_close_done: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      s_r.st == ACK_BALANCE_WAIT_STATE && s_r.cls && balanced && !CONN_ENTER
      |=> s_r.st == DONE_REQUEST_STATE && DONE_REASON == REASON_CLOSE)
      else $error("close did not request done");
   chk_ack_tmo_done: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      ACK_TMO |-> s_r.st == DONE_REQUEST_STATE
      && DONE_REASON == REASON_ACK_TMO)
      else $error("ack timeout path wrong");
   chk_credit_tmo_done: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      CREDIT_TMO |-> s_r.st == DONE_REQUEST_STATE
      && DONE_REASON == REASON_CREDIT_TMO)
      else $error("credit timeout path wrong");
   chk_credit_use: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      credit_used && !RRDY_RCVD && !CONN_ENTER
      |=> s_r.credit == $past(s_r.credit) - 1'b1)
      else $error("credit not consumed");
   chk_rrdy_adds: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      RRDY_RCVD && !credit_used && !CONN_ENTER
      |=> s_r.credit == $past(s_r.credit) + 1'b1)
      else $error("credit not added");
   chk_one_frame: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      frame_req
      |=> !frame_req)
      else $error("frame requested twice");
   chk_eof_counted: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      s_r.st == FRAME_REQUEST_STATE && eof_sent && !CONN_ENTER
      |=> IDLE && s_r.eof_cnt == $past(s_r.eof_cnt) + 1'b1)
      else $error("eof not counted");
   chk_done_notice: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      s_r.st == DONE_REQUEST_STATE && done_sent && !CONN_ENTER
      |=> IDLE && DONE_WAIT_REQ && DONE_SENT_CNF)
      else $error("done not confirmed");
   chk_ack_cnf: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      ACK_RCVD
      |=> ACK_RCVD_CNF)
      else $error("ack not confirmed");
   chk_conn_init: assert property (
      @(posedge CORE_CLK) disable iff (!RSTN)
      CONN_ENTER
      |=> balanced && !credit_avail)
      else $error("connection entry not initialised");
endmodule : sftx_top
